// ==== design/fpa_defs.svh ====
`ifndef FPA_DEFS_SVH
`define FPA_DEFS_SVH

// Register byte offsets
`define FPA_OFS_CTRL 12'h000
`define FPA_OFS_STEP 12'h004
`define FPA_OFS_PERIOD 12'h008
`define FPA_OFS_STATUS 12'h00c
`define FPA_OFS_SECWORD 12'h010
`define FPA_OFS_DACWORD 12'h014

// Field positions
`define FPA_CTRL_EN_BIT 0
`define FPA_STAT_OVR_BIT 0
`define FPA_STAT_ACT_LSB 1
`define FPA_STAT_DACV_BIT 3
`define FPA_CTL_UPPER_BIT 15
`define FPA_CTL_LOWER_BIT 14

// Reset values
`define FPA_RST_CTRL_EN 1'b0
`define FPA_RST_STEP 16'h0000

// Timing
`define FPA_CLK_PERIOD_NS 50
`define FPA_SAMPLE_TIME_NS 125000
`define FPA_SAMPLE_CYCLES (`FPA_SAMPLE_TIME_NS / `FPA_CLK_PERIOD_NS)
`define FPA_BIT_CYCLES 4
`define FPA_WORD_BITS 16

`endif

// ==== design/fpa_pkg.sv ====
package fpa_pkg;
	typedef enum logic [1:0] {
		FPA_ACT_NONE,
		FPA_ACT_DELAY,
		FPA_ACT_ADVANCE
	} fpa_act_t;

	typedef enum logic [1:0] {
		FPA_ST_IDLE,
		FPA_ST_PRIMARY,
		FPA_ST_SECONDARY
	} fpa_state_t;

	typedef logic [15:0] fpa_word_t;
endpackage

// ==== design/fpa_top.sv ====
`timescale 1ns/1ns
`include "fpa_defs.svh"

// Operation
// - Primary frame sync rise: take DAC bits 15..2
// - Same frame: shift out all ADC bits
// - Flag pins set the phase only with control 11; flags 11 also request a secondary frame
// - Control 01: delay next sample by step
// - Control 10: advance next sample by step
// - Negative step reverses every shift direction
// - Control 11, flags 01: delay; 00/11 none
// - Control 11, flags 10: advance by step
// - Other combinations: plain data exchange only
module fpa_top #(
	parameter int PERIOD_CYCLES = `FPA_SAMPLE_CYCLES,
	parameter int BIT_CYCLES = `FPA_BIT_CYCLES
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Serial port pins
	output logic o_frame_sync_n,
	output logic o_shift_clk,
	output logic o_dout,
	input wire logic i_din,
	input wire logic i_flag_pin_high,
	input wire logic i_flag_pin_low,
	// ADC sample source
	input wire fpa_pkg::fpa_word_t i_adc_data,
	// DAC word stream
	output fpa_pkg::fpa_word_t o_dac_data,
	output logic o_dac_valid,
	input wire logic i_dac_ready
);
	import fpa_pkg::*;

	localparam int SUB_W = $clog2(BIT_CYCLES + 1);

	// Pin synchronisers
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {i_din, i_flag_pin_high, i_flag_pin_low};
			sync2_r <= sync1_r;
		end
	end
	wire logic din_s = sync2_r[2];
	wire logic [1:0] flags_s = sync2_r[1:0];

	// Register file state
	logic ctrl_en_r, ctrl_en_nxt;
	logic signed [15:0] step_r, step_nxt;
	logic [15:0] period_r, period_nxt;
	logic ovr_r, ovr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic slverr_r, slverr_nxt;

	// Frame state
	fpa_state_t state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] len_r, len_nxt;
	logic [SUB_W-1:0] sub_r, sub_nxt;
	logic [3:0] slot_r, slot_nxt;
	fpa_word_t tx_r, tx_nxt;
	fpa_word_t rx_r, rx_nxt;
	logic sec_pend_r, sec_pend_nxt;
	fpa_word_t secword_r, secword_nxt;
	fpa_act_t last_act_r, last_act_nxt;

	// Two-entry DAC buffer
	fpa_word_t buf_mem_r [2];
	fpa_word_t buf_mem_nxt [2];
	logic buf_wp_r, buf_wp_nxt;
	logic buf_rp_r, buf_rp_nxt;
	logic [1:0] buf_cnt_r, buf_cnt_nxt;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_pop;
	fpa_word_t buf_in_data;

	assign buf_in_ready = (buf_cnt_r != 2'd2);
	assign buf_pop = o_dac_valid && i_dac_ready;
	assign o_dac_valid = (buf_cnt_r != 2'd0);
	assign o_dac_data = buf_mem_r[buf_rp_r];

	// Phase decode
	function automatic fpa_act_t decode_act(input logic [1:0] ctl, input logic [1:0] fl);
		fpa_act_t a;
		a = FPA_ACT_NONE;
		case (ctl)
			2'b01: a = FPA_ACT_DELAY;
			2'b10: a = FPA_ACT_ADVANCE;
			2'b11: begin
				// Flags only matter here
				if (fl == 2'b01) a = FPA_ACT_DELAY;
				else if (fl == 2'b10) a = FPA_ACT_ADVANCE;
			end
			default: a = FPA_ACT_NONE;
		endcase
		return a;
	endfunction

	// Adjusted length; signed step flips direction by itself
	function automatic logic [15:0] adj_len(input fpa_act_t a, input logic [15:0] base,
			input logic signed [15:0] st, input logic [15:0] now);
		logic signed [17:0] l;
		logic signed [17:0] floor_v;
		l = $signed({2'b00, base});
		floor_v = $signed({2'b00, now}) + 18'sd2;
		if (a == FPA_ACT_DELAY) l = l + 18'(st);
		else if (a == FPA_ACT_ADVANCE) l = l - 18'(st);
		// Never end the frame behind the counter
		if (l < floor_v) l = floor_v;
		if (l > 18'sh0ffff) l = 18'sh0ffff;
		return l[15:0];
	endfunction

	// Frame and shift engine
	always_comb begin
		fpa_act_t act;
		act = FPA_ACT_NONE;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		len_nxt = len_r;
		sub_nxt = sub_r;
		slot_nxt = slot_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		sec_pend_nxt = sec_pend_r;
		secword_nxt = secword_r;
		last_act_nxt = last_act_r;
		buf_in_valid = 1'b0;
		buf_in_data = 16'h0000;
		if (ctrl_en_r) begin
			if (cnt_r >= len_r - 16'd1) begin
				cnt_nxt = 16'h0000;
				// Shifted frame ends here; normal period resumes
				len_nxt = period_r;
			end else begin
				cnt_nxt = cnt_r + 16'd1;
			end
		end else begin
			cnt_nxt = 16'h0000;
			len_nxt = period_r;
		end
		case (state_r)
			FPA_ST_IDLE: begin
				sub_nxt = '0;
				slot_nxt = 4'h0;
				if (ctrl_en_r && cnt_r == 16'h0000) begin
					state_nxt = FPA_ST_PRIMARY;
					tx_nxt = i_adc_data;
				end else if (ctrl_en_r && sec_pend_r && cnt_r == {1'b0, len_r[15:1]}) begin
					state_nxt = FPA_ST_SECONDARY;
					tx_nxt = 16'h0000;
					sec_pend_nxt = 1'b0;
				end
			end
			FPA_ST_PRIMARY, FPA_ST_SECONDARY: begin
				if (sub_r == SUB_W'(BIT_CYCLES - 1)) begin
					sub_nxt = '0;
					rx_nxt = {rx_r[14:0], din_s};
					tx_nxt = {tx_r[14:0], 1'b0};
					slot_nxt = slot_r + 4'h1;
					if (slot_r == 4'hf) begin
						state_nxt = FPA_ST_IDLE;
						if (state_r == FPA_ST_PRIMARY) begin
							// Keep only the DAC bits
							buf_in_valid = 1'b1;
							buf_in_data = {rx_r[14:1], 2'b00};
							sec_pend_nxt = (rx_r[0] && din_s) || (flags_s == 2'b11);
						end else begin
							secword_nxt = {rx_r[14:0], din_s};
							act = decode_act({rx_r[14], rx_r[13]}, flags_s);
							last_act_nxt = act;
							len_nxt = adj_len(act, len_r, step_r, cnt_r);
						end
					end
				end else begin
					sub_nxt = sub_r + SUB_W'(1);
				end
			end
			default: state_nxt = FPA_ST_IDLE;
		endcase
		if (!ctrl_en_r) begin
			state_nxt = FPA_ST_IDLE;
			sec_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_r <= FPA_ST_IDLE;
			cnt_r <= 16'h0000;
			len_r <= 16'(PERIOD_CYCLES);
			sub_r <= '0;
			slot_r <= 4'h0;
			tx_r <= 16'h0000;
			rx_r <= 16'h0000;
			sec_pend_r <= 1'b0;
			secword_r <= 16'h0000;
			last_act_r <= FPA_ACT_NONE;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			len_r <= len_nxt;
			sub_r <= sub_nxt;
			slot_r <= slot_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			sec_pend_r <= sec_pend_nxt;
			secword_r <= secword_nxt;
			last_act_r <= last_act_nxt;
		end
	end

	// Pin drive from flops
	assign o_frame_sync_n = (state_r == FPA_ST_IDLE);
	assign o_shift_clk = (state_r != FPA_ST_IDLE) && (sub_r < SUB_W'(BIT_CYCLES / 2));
	assign o_dout = (state_r != FPA_ST_IDLE) && tx_r[15];

	// Buffer; a full buffer drops the word and flags overrun
	always_comb begin
		buf_mem_nxt = buf_mem_r;
		buf_wp_nxt = buf_wp_r;
		buf_rp_nxt = buf_rp_r;
		buf_cnt_nxt = buf_cnt_r;
		if (buf_in_valid && buf_in_ready) begin
			buf_mem_nxt[buf_wp_r] = buf_in_data;
			buf_wp_nxt = ~buf_wp_r;
		end
		if (buf_pop) buf_rp_nxt = ~buf_rp_r;
		buf_cnt_nxt = buf_cnt_r + {1'b0, buf_in_valid && buf_in_ready} - {1'b0, buf_pop};
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			buf_mem_r <= '{default: 16'h0000};
			buf_wp_r <= 1'b0;
			buf_rp_r <= 1'b0;
			buf_cnt_r <= 2'd0;
		end else begin
			buf_mem_r <= buf_mem_nxt;
			buf_wp_r <= buf_wp_nxt;
			buf_rp_r <= buf_rp_nxt;
			buf_cnt_r <= buf_cnt_nxt;
		end
	end

	// APB slave; zero wait states, read data latched in setup
	logic setup_ph;
	logic access_wr;
	assign setup_ph = i_psel && !i_penable;
	assign access_wr = i_psel && i_penable && i_pwrite;
	assign o_pready = 1'b1;
	assign o_prdata = prdata_r;
	assign o_pslverr = slverr_r && i_psel && i_penable;

	always_comb begin
		ctrl_en_nxt = ctrl_en_r;
		step_nxt = step_r;
		period_nxt = period_r;
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		// Set wins over write-one-clear
		ovr_nxt = ovr_r;
		if (access_wr && i_paddr == `FPA_OFS_STATUS && i_pwdata[`FPA_STAT_OVR_BIT]) ovr_nxt = 1'b0;
		if (buf_in_valid && !buf_in_ready) ovr_nxt = 1'b1;
		if (access_wr) begin
			if (i_paddr == `FPA_OFS_CTRL) begin
				ctrl_en_nxt = i_pwdata[`FPA_CTRL_EN_BIT];
			end else if (i_paddr == `FPA_OFS_STEP) begin
				step_nxt = i_pwdata[15:0];
			end else if (i_paddr == `FPA_OFS_PERIOD) begin
				period_nxt = i_pwdata[15:0];
			end
		end
		if (setup_ph) begin
			slverr_nxt = 1'b0;
			prdata_nxt = 32'h0000_0000;
			if (i_paddr == `FPA_OFS_CTRL) begin
				prdata_nxt[`FPA_CTRL_EN_BIT] = ctrl_en_r;
			end else if (i_paddr == `FPA_OFS_STEP) begin
				prdata_nxt[15:0] = step_r;
			end else if (i_paddr == `FPA_OFS_PERIOD) begin
				prdata_nxt[15:0] = period_r;
			end else if (i_paddr == `FPA_OFS_STATUS) begin
				prdata_nxt[`FPA_STAT_OVR_BIT] = ovr_r;
				prdata_nxt[`FPA_STAT_ACT_LSB +: 2] = last_act_r;
				prdata_nxt[`FPA_STAT_DACV_BIT] = o_dac_valid;
			end else if (i_paddr == `FPA_OFS_SECWORD) begin
				prdata_nxt[15:0] = secword_r;
			end else if (i_paddr == `FPA_OFS_DACWORD) begin
				prdata_nxt[15:0] = o_dac_data;
			end else begin
				slverr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			ctrl_en_r <= `FPA_RST_CTRL_EN;
			step_r <= `FPA_RST_STEP;
			period_r <= 16'(PERIOD_CYCLES);
			ovr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else begin
			ctrl_en_r <= ctrl_en_nxt;
			step_r <= step_nxt;
			period_r <= period_nxt;
			ovr_r <= ovr_nxt;
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end
endmodule

// ==== dv/fpa_host.sv ====
`timescale 1ns/1ns
module fpa_host (
	// Frame pins
	input wire logic i_clock,
	input wire logic i_frame_sync_n,
	input wire logic i_shift_clk,
	input wire logic i_dout,
	output logic o_din,
	// Words
	input wire logic [15:0] i_tx,
	output logic [15:0] o_rx
);
	logic [15:0] sh_r = 16'h0000;
	logic [15:0] rcv_r = 16'h0000;
	logic sq_r = 1'b0;
	initial o_din = 1'b0;
	initial o_rx = 16'h0000;
	always @(posedge i_clock) begin
		sq_r <= i_shift_clk;
		if (i_frame_sync_n) begin
			sh_r <= i_tx;
			o_rx <= rcv_r;
			o_din <= ~o_din; // Toggles so no stale bit passes
		end else if (i_shift_clk && !sq_r) begin
			o_din <= sh_r[15];
			sh_r <= sh_r << 1;
		end else if (!i_shift_clk && sq_r) begin
			rcv_r <= {rcv_r[14:0], i_dout};
		end
	end
endmodule

// ==== dv/fpa_sva.sv ====
`timescale 1ns/1ns
`include "fpa_defs.svh"
module fpa_sva #(parameter int BIT_CYCLES = 4) (
	// Bus
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Serial and stream
	input wire logic o_frame_sync_n,
	input wire logic o_shift_clk,
	input wire logic o_dout,
	input wire fpa_pkg::fpa_word_t o_dac_data,
	input wire logic o_dac_valid,
	input wire logic i_dac_ready
);
	import fpa_pkg::*;
	logic [15:0] low_r, low_nxt;
	always_comb low_nxt = o_frame_sync_n ? 16'h0000 : low_r + 16'h0001;
	always_ff @(posedge i_clock) low_r <= i_reset_n ? low_nxt : 16'h0000;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	sequence s_bad_rd;
		i_psel && !i_penable && !i_pwrite && i_paddr > `FPA_OFS_DACWORD ##1 i_penable;
	endsequence
	property p_len; $rose(o_frame_sync_n) |-> low_r == 16 * BIT_CYCLES; endproperty
	property p_sclk; !o_frame_sync_n |-> o_shift_clk == (low_r % BIT_CYCLES < BIT_CYCLES / 2); endproperty
	property p_dout; !o_frame_sync_n && low_r % BIT_CYCLES != 0 |-> $stable(o_dout); endproperty
	property p_idle; o_frame_sync_n && $past(o_frame_sync_n) |-> !o_shift_clk && !o_dout; endproperty
	property p_rd_err; s_bad_rd |-> o_pslverr && o_prdata == 32'h0; endproperty
	property p_err_gate; o_pslverr |-> i_psel && i_penable; endproperty
	property p_ready; o_pready; endproperty
	property p_hold; o_dac_valid && !i_dac_ready |=> o_dac_valid && $stable(o_dac_data); endproperty
	property p_lsb; o_dac_valid |-> o_dac_data[1:0] == 2'b00; endproperty
	a_len: assert property (p_len) else $error("frame length");
	a_sclk: assert property (p_sclk) else $error("slot clock");
	a_dout: assert property (p_dout) else $error("dout moved in slot");
	a_idle: assert property (p_idle) else $error("idle pins");
	a_rd_err: assert property (p_rd_err) else $error("unmapped read");
	a_err_gate: assert property (p_err_gate) else $error("stray pslverr");
	a_ready: assert property (p_ready) else $error("pready low");
	a_hold: assert property (p_hold) else $error("stalled word lost");
	a_lsb: assert property (p_lsb) else $error("dac low bits");
endmodule
bind fpa_top fpa_sva #(.BIT_CYCLES(BIT_CYCLES)) i_sva (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_frame_sync_n(o_frame_sync_n), .o_shift_clk(o_shift_clk),
	.o_dout(o_dout), .o_dac_data(o_dac_data), .o_dac_valid(o_dac_valid), .i_dac_ready(i_dac_ready)
);

// ==== dv/test_frame_phase_adjust.sv ====
`timescale 1ns/1ns
`include "fpa_defs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module test_frame_phase_adjust;
	import fpa_pkg::*;
	localparam int PER = 200;
	logic i_clock = 0, i_reset_n = 0, psel = 0, pen = 0, pwr = 0, fh = 0, fl = 0, rdy = 1, fsq = 1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h0, prdata, rd;
	logic pready, pslverr, fs_n, sclk, dout, din, dval, err;
	fpa_word_t adc = 16'h9c35, tx = 16'h1230, dac, rx;
	int n_errors = 0, num_checks = 0, cyc = 0, nf = 0, lastp = -999;
	int pf[$];
	logic [1:0] cs[11] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
	logic [1:0] fg[11] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2, 2'h0, 2'h0, 2'h1};
	int dl[11] = '{10, -10, 10, -10, 0, 0, 0, 0, -10, 10, -10};
	fpa_top #(.PERIOD_CYCLES(PER)) i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_frame_sync_n(fs_n),
		.o_shift_clk(sclk), .o_dout(dout), .i_din(din), .i_flag_pin_high(fh), .i_flag_pin_low(fl),
		.i_adc_data(adc), .o_dac_data(dac), .o_dac_valid(dval), .i_dac_ready(rdy));
	fpa_host i_host (.i_clock(i_clock), .i_frame_sync_n(fs_n), .i_shift_clk(sclk),
		.i_dout(dout), .o_din(din), .i_tx(tx), .o_rx(rx));
	initial forever #25 i_clock = ~i_clock;
	// Secondary falls sit mid-frame, so only long gaps mark a primary
	always @(posedge i_clock) begin
		cyc++;
		fsq <= fs_n;
		if (fsq && !fs_n) begin
			nf++;
			if (cyc - lastp > 150) begin
				pf.push_back(cyc);
				lastp = cyc;
			end
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge i_clock);
		pen <= 1;
		do @(posedge i_clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
	endtask
	task w(input bit prim);
		int n;
		n = prim ? pf.size() : nf;
		for (int i = 0; i < 400 && (prim ? pf.size() : nf) == n; i++) @(posedge i_clock);
	endtask
	task sc_phase(input logic [1:0] c, input logic [1:0] f, input int d);
		int t0;
		fh <= f[1];
		fl <= f[0];
		tx <= 16'h0003;
		w(1);
		w(1);
		t0 = pf[$];
		tx <= {c, 14'h0000};
		w(0);
		tx <= 16'h1230;
		w(1);
		w(1);
		`CHK(pf[$-1] - t0, PER + d)
		`CHK(pf[$] - pf[$-1], PER)
		apb(0, `FPA_OFS_SECWORD, 0);
		`CHK(rd[15:0], (f == 2'b11) ? 16'h1230 : {c, 14'h0000})
		$display("phase %b %b done", c, f);
	endtask
	task sc_data;
		tx <= 16'hb6c4;
		w(1);
		rdy <= 0;
		repeat (3) w(1);
		`CHK(rx, adc)
		`CHK({dval, dac}, {1'b1, 16'hb6c4})
		apb(0, `FPA_OFS_STATUS, 0);
		`CHK(rd[`FPA_STAT_OVR_BIT], 1'b1)
		rdy <= 1;
		@(posedge i_clock);
		@(posedge i_clock);
		rdy <= 0;
		@(posedge i_clock);
		`CHK(dval, 1'b0)
		$display("data done");
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clock);
		n_errors++;
		results;
	end
	initial begin
		repeat (2) @(posedge i_clock);
		i_reset_n <= 1;
		apb(0, `FPA_OFS_STEP, 0);
		`CHK(rd[15:0], `FPA_RST_STEP)
		apb(0, 12'h0f0, 0);
		`CHK({err, rd}, {1'b1, 32'h0})
		$display("regs done");
		apb(1, `FPA_OFS_PERIOD, PER);
		apb(1, `FPA_OFS_STEP, 32'h0000000a);
		apb(1, `FPA_OFS_CTRL, 32'h00000001);
		for (int i = 0; i < 11; i++) begin
			if (i == 8) apb(1, `FPA_OFS_STEP, 32'h0000fff6);
			sc_phase(cs[i], fg[i], dl[i]);
		end
		sc_data;
		results;
	end
endmodule
